/* File: logic/tsal_alert.sv */
/*
 * Thermal set-point alert logic: sample register, two limit registers,
 * configuration byte, fault counter and open-drain alert output.
 * Assumes a serial bus engine on i_clk_sys issues one-cycle read/write
 * strobes with pointer, and that the converter runs on its own clock and
 * presents a result with a one-cycle done strobe on that clock.
 */
`include "tsal_consts.svh"

module tsal_alert (
  // System clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset,
  // Converter side, own clock domain
  input  wire logic                  i_clk_conv,
  input  wire logic                  i_reset_conv,
  input  wire tsal_pkg::tsal_sample_t i_conv_result,
  input  wire logic                  i_conv_done,
  output logic                       o_conv_halt,
  // Register access from the serial bus engine
  input  wire tsal_pkg::tsal_access_t i_access,
  output logic [15:0]                o_rdata,
  // Open-drain alert pin
  input  wire logic                  i_alert_output,
  output logic                       o_alert_output,
  output logic                       o_alert_output_oe
);

  // ---------------------------------------------------------------
  // Converter domain: capture and toggle event
  // ---------------------------------------------------------------
  logic [12:0] conv_hold_reg;
  logic [12:0] conv_hold_next;
  logic        conv_tog_reg;
  logic        conv_tog_next;
  logic        halt_c1_reg;
  logic        halt_c2_reg;
  logic        halt_select_bit;

  always_comb begin
    conv_hold_next = conv_hold_reg;
    conv_tog_next  = conv_tog_reg;
    if (i_conv_done && !halt_c2_reg) begin
      conv_hold_next = i_conv_result.value;
      conv_tog_next  = ~conv_tog_reg;
    end
  end

  always_ff @(posedge i_clk_conv) begin
    if (i_reset_conv) begin
      conv_hold_reg <= 13'h0000;
      conv_tog_reg  <= 1'b0;
      halt_c1_reg   <= 1'b0;
      halt_c2_reg   <= 1'b0;
    end else begin
      conv_hold_reg <= conv_hold_next;
      conv_tog_reg  <= conv_tog_next;
      halt_c1_reg   <= halt_select_bit;
      halt_c2_reg   <= halt_c1_reg;
    end
  end

  assign o_conv_halt = halt_c2_reg;

  // ---------------------------------------------------------------
  // System domain: event crossing
  // ---------------------------------------------------------------
  // Held word is stable for many system cycles after the toggle moves
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic conv_evt;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= conv_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  assign conv_evt = tog_s2_reg ^ tog_s3_reg;

  // Pin readback feeds only the drive check below; two stages keep it clean
  logic pin_s1_reg;
  logic pin_s2_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= i_alert_output;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] sample_reg;
  logic [15:0] sample_next;
  logic [8:0]  overheat_reg;
  logic [8:0]  overheat_next;
  logic [8:0]  release_reg;
  logic [8:0]  release_next;
  logic [7:0]  config_reg;
  logic [7:0]  config_next;
  logic        halt_rise;
  logic        halt_d_reg;

  always_comb begin
    sample_next   = sample_reg;
    overheat_next = overheat_reg;
    release_next  = release_reg;
    config_next   = config_reg;
    if (conv_evt) begin
      sample_next = {conv_hold_reg, 3'h0} & `TSAL_SAMPLE_LOW_MASK;
    end
    if (i_access.wr) begin
      unique case (i_access.ptr)
        `TSAL_PTR_CONFIG:   config_next   = i_access.wdata[7:0];
        `TSAL_PTR_OVERHEAT: overheat_next = i_access.wdata[15:7];
        `TSAL_PTR_RELEASE:  release_next  = i_access.wdata[15:7];
        default:            config_next   = config_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sample_reg   <= 16'h0000;
      overheat_reg <= `TSAL_OVERHEAT_RST;
      release_reg  <= `TSAL_RELEASE_RST;
      config_reg   <= `TSAL_CONFIG_RST;
      halt_d_reg   <= 1'b0;
    end else begin
      sample_reg   <= sample_next;
      overheat_reg <= overheat_next;
      release_reg  <= release_next;
      config_reg   <= config_next;
      halt_d_reg   <= halt_select_bit;
    end
  end

  assign halt_select_bit = config_reg[`TSAL_CFG_HALT_POS];
  assign halt_rise       = halt_select_bit & ~halt_d_reg;

  // Read data registered; unmapped pointers read zero
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (i_access.rd) begin
      unique case (i_access.ptr)
        `TSAL_PTR_SAMPLE:   rdata_next = sample_reg;
        `TSAL_PTR_CONFIG:   rdata_next = {8'h00, config_reg};
        `TSAL_PTR_OVERHEAT: rdata_next = {overheat_reg, `TSAL_LIMIT_PAD};
        `TSAL_PTR_RELEASE:  rdata_next = {release_reg, `TSAL_LIMIT_PAD};
        default:            rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // Comparison and fault counting
  // ---------------------------------------------------------------
  logic signed [8:0] top9;
  logic              above;
  logic              below;
  logic [2:0]        need;
  logic              behaviour_select_bit;
  logic              level_select_bit;
  logic [1:0]        consecutive_fault_count;

  assign top9 = $signed(conv_hold_reg[12:4]);
  assign above = top9 > $signed(overheat_reg);
  assign below = top9 < $signed(release_reg);
  assign behaviour_select_bit = config_reg[`TSAL_CFG_BEHAV_POS];
  assign level_select_bit     = config_reg[`TSAL_CFG_LEVEL_POS];
  assign consecutive_fault_count = config_reg[`TSAL_CFG_FQ_HI_POS:`TSAL_CFG_FQ_LO_POS];

  // Coded field, not a plain count: code 3 asks for six faults
  always_comb begin
    unique case (consecutive_fault_count)
      2'h0: need = `TSAL_FQ_CODE0;
      2'h1: need = `TSAL_FQ_CODE1;
      2'h2: need = `TSAL_FQ_CODE2;
      2'h3: need = `TSAL_FQ_CODE3;
    endcase
  end

  // ---------------------------------------------------------------
  // Alert state
  // ---------------------------------------------------------------
  logic                int_set;
  logic                clear_req;
  logic [2:0]          fault_cnt_reg;
  logic [2:0]          fault_cnt_next;
  logic                alert_reg;
  logic                alert_next;
  tsal_pkg::tsal_arm_t arm_reg;
  tsal_pkg::tsal_arm_t arm_next;
  logic                fault;
  logic [2:0]          cnt_inc;

  // Fault meaning depends on mode and which limit is armed
  always_comb begin
    if (behaviour_select_bit) begin
      fault = (arm_reg == tsal_pkg::TSAL_ARM_HIGH) ? above : below;
    end else begin
      fault = alert_reg ? below : above;
    end
    cnt_inc = fault_cnt_reg + 3'h1;
  end

  always_comb begin
    fault_cnt_next = fault_cnt_reg;
    alert_next     = alert_reg;
    arm_next       = arm_reg;
    int_set        = 1'b0;
    clear_req      = i_access.rd || halt_rise;
    if (conv_evt) begin
      if (!fault) begin
        fault_cnt_next = 3'h0;
      end else if (cnt_inc >= need) begin
        fault_cnt_next = 3'h0;
        if (behaviour_select_bit) begin
          // A latched alert swallows crossings unless it is cleared now
          if (!alert_reg || clear_req) begin
            int_set    = 1'b1;
            alert_next = 1'b1;
            arm_next   = (arm_reg == tsal_pkg::TSAL_ARM_HIGH) ?
                         tsal_pkg::TSAL_ARM_LOW : tsal_pkg::TSAL_ARM_HIGH;
          end
        end else begin
          alert_next = ~alert_reg;
        end
      end else begin
        fault_cnt_next = cnt_inc;
      end
    end
    // Crossing and clear in one cycle: the crossing wins, no event lost
    if (behaviour_select_bit && alert_reg && clear_req && !int_set) begin
      alert_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      fault_cnt_reg <= 3'h0;
      alert_reg     <= 1'b0;
      arm_reg       <= tsal_pkg::TSAL_ARM_HIGH;
    end else begin
      fault_cnt_reg <= fault_cnt_next;
      alert_reg     <= alert_next;
      arm_reg       <= arm_next;
    end
  end

  // Open drain: only ever drives low, pull-up makes high
  logic drive_low;
  assign drive_low = alert_reg ^ level_select_bit;
  assign o_alert_output    = 1'b0;
  assign o_alert_output_oe = drive_low;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_alert_reset_low: assert property (@(posedge i_clk_sys)
    i_reset |=> !alert_reg && fault_cnt_reg == 3'h0)
    else $error("alert or counter not cleared by reset");

  a_pin_level: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_alert_output_oe == (alert_reg != level_select_bit))
    else $error("alert pin level mismatch");

  a_open_drain: assert property (@(posedge i_clk_sys)
    o_alert_output == 1'b0)
    else $error("alert pin driven high");

  a_limit_read_pad: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_access.rd && (i_access.ptr == `TSAL_PTR_OVERHEAT || i_access.ptr == `TSAL_PTR_RELEASE)
    |=> o_rdata[6:0] == 7'h00)
    else $error("limit low bits not zero");

  a_sample_load: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    conv_evt |=> sample_reg[15:3] == $past(conv_hold_reg) && sample_reg[2:0] == 3'h0)
    else $error("sample not loaded");

  a_comp_read_keep: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !behaviour_select_bit && !conv_evt && !i_access.wr |=> alert_reg == $past(alert_reg))
    else $error("comparator alert changed without conversion");

  a_int_clear_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    behaviour_select_bit && alert_reg && i_access.rd && !conv_evt && !i_access.wr
    |=> !alert_reg)
    else $error("interrupt alert not cleared by read");

  a_fault_single: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    conv_evt && !behaviour_select_bit && !alert_reg && above && need == 3'h1 && !i_access.wr
    |=> alert_reg)
    else $error("single fault did not assert alert");

  a_strict_compare: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    conv_evt && !behaviour_select_bit && !alert_reg && top9 == $signed(overheat_reg)
    && !i_access.wr |=> !alert_reg)
    else $error("equal sample tripped alert");

  a_halt_clear_int: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    behaviour_select_bit && alert_reg && halt_rise && !conv_evt |=> !alert_reg)
    else $error("interrupt alert not cleared by shutdown");

  a_int_arm_swap: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    conv_evt && behaviour_select_bit && !alert_reg && arm_reg == tsal_pkg::TSAL_ARM_HIGH
    && above && need == 3'h1 && !i_access.wr
    |=> alert_reg && arm_reg == tsal_pkg::TSAL_ARM_LOW)
    else $error("interrupt trigger did not move to lower limit");

  a_pin_readback: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $past(o_alert_output_oe, 2) |-> !pin_s2_reg)
    else $error("alert pin not low while pulled");

  a_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_access.rd |=> $stable(o_rdata))
    else $error("read data moved without a read");

  // Converter domain check, on its own clock and reset
  a_halt_drops_done: assert property (@(posedge i_clk_conv) disable iff (i_reset_conv)
    i_conv_done && halt_c2_reg |=> conv_tog_reg == $past(conv_tog_reg))
    else $error("conversion taken while halted");

endmodule

/* File: logic/tsal_consts.svh */
/*
 * Constants for the thermal set-point alert block: register layout, reset
 * values, configuration fields and fault-count table.
 * Assumes inclusion from the top module only.
 */
// Notes on behaviour
// - Sample register reloads at each conversion end
// - Sample is 13-bit signed, left aligned
// - Limits are RW, nine bits, left aligned
// - Each conversion end compares one limit, picked by mode and alert/arm state
// - Comparison uses nine top sample bits
// - Limit reads return low seven bits zero
// - Level select bit sets asserted level
// - Behaviour select bit chooses interrupt/comparator
// - Comparator: set above, clear below, sticky
// - Interrupt: latched until read or shutdown
// - Alert pin is open drain
// - Interrupt triggers alternate between limits
// - Alert needs programmed consecutive fault count
// - Halt bit stops conversions, registers live
`ifndef TSAL_CONSTS_SVH
`define TSAL_CONSTS_SVH

`define TSAL_PTR_SAMPLE      8'h00
`define TSAL_PTR_CONFIG      8'h01
`define TSAL_PTR_RELEASE     8'h02
`define TSAL_PTR_OVERHEAT    8'h03

`define TSAL_OVERHEAT_RST    9'h0A0
`define TSAL_RELEASE_RST     9'h096
`define TSAL_CONFIG_RST      8'h00

`define TSAL_CFG_HALT_POS    0
`define TSAL_CFG_BEHAV_POS   1
`define TSAL_CFG_LEVEL_POS   2
`define TSAL_CFG_FQ_LO_POS   3
`define TSAL_CFG_FQ_HI_POS   4

`define TSAL_FQ_CODE0        3'h1
`define TSAL_FQ_CODE1        3'h2
`define TSAL_FQ_CODE2        3'h4
`define TSAL_FQ_CODE3        3'h6

`define TSAL_SAMPLE_LOW_MASK 16'hFFF8
`define TSAL_LIMIT_PAD       7'h00

`endif

/* File: logic/tsal_pkg.sv */
/*
 * Types for the thermal set-point alert block.
 * Assumes the constants header is on the include path.
 */
package tsal_pkg;

  typedef struct packed {
    logic [7:0]  ptr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } tsal_access_t;

  typedef struct packed {
    logic [12:0] value;
  } tsal_sample_t;

  typedef enum logic [1:0] {
    TSAL_ARM_HIGH = 2'b01,
    TSAL_ARM_LOW  = 2'b10
  } tsal_arm_t;

endpackage

/* File: verif/testbench.sv */
/*
 * Self-checking bench for the thermal set-point alert block.
 * Assumes a pull-up on the alert pin and a free-running converter clock.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk      = 1'b0;
  logic                   clk_conv = 1'b0;
  logic                   rst      = 1'b1;
  logic                   rst_conv = 1'b1;
  logic                   done     = 1'b0;
  tsal_pkg::tsal_sample_t res      = '0;
  tsal_pkg::tsal_access_t acc;
  logic [15:0]            rdata;
  logic [15:0]            d;
  logic                   halt;
  logic                   a_out;
  logic                   a_oe;
  wire logic              pin;
  int                     mismatches = 0;
  int                     num_checks = 0;
  int                     n;

  // ----------------------------------------
  // Clocks, pin and instances
  // ----------------------------------------
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #40 clk_conv = ~clk_conv;
  end

  // Pull-up wins whenever the block lets go
  assign pin = a_oe ? a_out : 1'b1;

  tsal_host_model host (.i_clk_sys(clk), .i_rdata(rdata), .o_access(acc));

  tsal_alert DUT (
    .i_clk_sys        (clk),
    .i_reset          (rst),
    .i_clk_conv       (clk_conv),
    .i_reset_conv     (rst_conv),
    .i_conv_result    (res),
    .i_conv_done      (done),
    .o_conv_halt      (halt),
    .i_access         (acc),
    .o_rdata          (rdata),
    .i_alert_output   (pin),
    .o_alert_output   (a_out),
    .o_alert_output_oe(a_oe)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic do_reset;
    rst = 1'b1;
    rst_conv = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk_conv);
    rst_conv = 1'b0;
  endtask

  // Spacing leaves room for the crossing into the system domain
  task automatic conv(input logic [12:0] v);
    @(negedge clk_conv);
    res.value = v;
    done = 1'b1;
    @(negedge clk_conv);
    done = 1'b0;
    repeat (3) @(negedge clk_conv);
  endtask

  task automatic set_halt(input logic [15:0] cfg);
    host.wr(8'h01, cfg);
    repeat (8) @(negedge clk_conv);
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200us;
    mismatches++;
    give_verdict();
  end

  initial begin
    do_reset();
    host.rd(8'h03, d);
    chk16(d, 16'h5000);
    host.rd(8'h02, d);
    chk16(d, 16'h4B00);
    host.rd(8'h01, d);
    chk16(d, 16'h0000);
    chkb(pin, 1'b1);
    chkb(a_out, 1'b0);
    chkb(halt, 1'b0);
    host.wr(8'h03, 16'hFFFF);
    host.rd(8'h03, d);
    chk16(d, 16'hFF80);
    host.wr(8'h03, 16'h1900);
    host.wr(8'h02, 16'h1400);
    conv(13'h1F38);
    host.rd(8'h00, d);
    chk16(d & 16'hFFF8, 16'hF9C0);
    chk16({7'h00, host.half_deg(d)}, 16'h01F3);
    host.wr(8'h00, 16'h0000);
    host.rd(8'h00, d);
    chk16(d & 16'hFFF8, 16'hF9C0);
    conv(13'h032F);
    chkb(pin, 1'b1);
    conv(13'h0330);
    chkb(pin, 1'b0);
    host.rd(8'h00, d);
    chk16(d & 16'hFFF8, 16'h1980);
    chkb(pin, 1'b0);
    conv(13'h0280);
    chkb(pin, 1'b0);
    set_halt(16'h0001);
    chkb(halt, 1'b1);
    chkb(pin, 1'b0);
    host.rd(8'h01, d);
    chk16(d, 16'h0001);
    conv(13'h0270);
    chkb(pin, 1'b0);
    set_halt(16'h0000);
    chkb(halt, 1'b0);
    conv(13'h0270);
    chkb(pin, 1'b1);
    host.wr(8'h01, 16'h0004);
    chkb(pin, 1'b0);
    conv(13'h0330);
    chkb(pin, 1'b1);
    conv(13'h0270);
    chkb(pin, 1'b0);
    // Every fault-count code, with the threshold approached from one short
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : 2 * c;
      host.wr(8'h01, {11'h000, c[1:0], 3'h0});
      repeat (n - 1) conv(13'h0330);
      chkb(pin, 1'b1);
      conv(13'h0330);
      chkb(pin, 1'b0);
      repeat (n - 1) conv(13'h0270);
      chkb(pin, 1'b0);
      conv(13'h0270);
      chkb(pin, 1'b1);
    end
    // Mid-run reset taken with the alert asserted
    host.wr(8'h01, 16'h0000);
    conv(13'h0330);
    chkb(pin, 1'b0);
    @(negedge clk);
    do_reset();
    chkb(pin, 1'b1);
    host.wr(8'h03, 16'h1900);
    host.wr(8'h02, 16'h1400);
    host.wr(8'h01, 16'h0002);
    conv(13'h0270);
    chkb(pin, 1'b1);
    conv(13'h0330);
    chkb(pin, 1'b0);
    conv(13'h0330);
    chkb(pin, 1'b0);
    host.rd(8'h07, d);
    chk16(d, 16'h0000);
    chkb(pin, 1'b1);
    conv(13'h0330);
    chkb(pin, 1'b1);
    conv(13'h0270);
    chkb(pin, 1'b0);
    set_halt(16'h0003);
    chkb(pin, 1'b1);
    set_halt(16'h0002);
    conv(13'h0330);
    chkb(pin, 1'b0);
    give_verdict();
  end
endmodule

/* File: verif/tsal_host_model.sv */
/*
 * Register bus host model: one-cycle read and write strobes with pointer.
 * Assumes the block samples strobes on the rising system clock edge.
 */
module tsal_host_model (
  // Clock
  input  wire logic                   i_clk_sys,
  // Register access
  input  wire logic [15:0]            i_rdata,
  output tsal_pkg::tsal_access_t      o_access
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_access = '0;

  // Strobes move at the falling edge, half a cycle clear of sampling
  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    @(negedge i_clk_sys);
    o_access = '{ptr: ptr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(negedge i_clk_sys);
    o_access.wr = 1'b0;
    @(negedge i_clk_sys);
  endtask

  // Whole word taken; trimming precision is the caller's choice
  task automatic rd(input logic [7:0] ptr, output logic [15:0] data);
    @(negedge i_clk_sys);
    o_access = '{ptr: ptr, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(negedge i_clk_sys);
    o_access.rd = 1'b0;
    @(negedge i_clk_sys);
    data = i_rdata;
  endtask

  // Half-degree signed reading from the nine top bits
  function automatic logic signed [8:0] half_deg(input logic [15:0] word);
    return word[15:7];
  endfunction
endmodule
